// ===== wseq_delay.sv
/*
 * Idle-step timer: counts count x STEP_CYCLES clock cycles, then
 * pulses done.
 * Assumes start and abort are never high together and count is
 * non-zero when start is given.
 */
`timescale 1ns/1ns
module wseq_delay #(
   parameter int unsigned STEP_CYCLES = wseq_pkg::STEP_CYCLES
) (
   // clock and reset
   input  wire logic   clock,
   input  wire logic   rst_n,
   // sequencer side
   wseq_delay_if.timer dly
);
   import wseq_pkg::*;

   localparam int TICK_W = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(STEP_CYCLES - 1);

   typedef struct packed {
      logic [TICK_W-1:0]  tick;
      logic [VALUE_W-1:0] left;
      logic               busy;
      logic               done;
   } wseq_dly_t;

   wseq_dly_t st_reg;
   wseq_dly_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      if (st_reg.busy) begin
         if (st_reg.tick == TICK_LAST) begin
            st_next.tick = '0;
            if (st_reg.left == VALUE_W'(1)) begin
               st_next.busy = 1'b0;
               st_next.done = 1'b1;
            end else begin
               st_next.left = st_reg.left - VALUE_W'(1);
            end
         end else begin
            st_next.tick = st_reg.tick + TICK_W'(1);
         end
      end
      if (dly.start) begin
         st_next.tick = '0;
         st_next.left = dly.count;
         st_next.busy = (dly.count != '0);
      end
      // abort wins so a stopped chain never sees a late done
      if (dly.abort) begin
         st_next.busy = 1'b0;
         st_next.done = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign dly.busy = st_reg.busy;
   assign dly.done = st_reg.done;

   // helper: cycles since start, for the length check
   int unsigned elapsed_reg;
   int unsigned steps_reg;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         elapsed_reg <= 0;
         steps_reg   <= 0;
      end else if (dly.start) begin
         elapsed_reg <= 0;
         steps_reg   <= 32'(dly.count);
      end else if (st_reg.busy) begin
         elapsed_reg <= elapsed_reg + 1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   delay_length_a: assert property (
      st_reg.done |-> elapsed_reg == steps_reg * STEP_CYCLES)
      else $error("idle period length wrong");

endmodule // wseq_delay

// ===== wseq_delay_if.sv
/*
 * Handshake between the slot sequencer and its idle-step timer.
 * Assumes both ends share the one system clock.
 */
`timescale 1ns/1ns
interface wseq_delay_if;
   logic       start;   // one-cycle pulse, loads count
   logic       abort;   // one-cycle pulse, drops a running delay
   logic [6:0] count;   // number of idle steps
   logic       done;    // one-cycle pulse at delay end
   logic       busy;    // level while delaying

   modport ctrl  (output start, output abort, output count,
                  input done, input busy);
   modport timer (input start, input abort, input count,
                  output done, output busy);
endinterface

// ===== wseq_pkg.sv
/*
 * Shared constants for the waveform sequence slot block: register
 * offsets, slot field layout, reset values, sequencer states and the
 * idle-step timing.
 * Assumes a single 25 MHz clock and an 8-bit register port.
 */
package wseq_pkg;

   // register port geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [7:0] ADDR_TRIG        = 8'h0C;
   localparam logic [7:0] ADDR_SLOT_FIRST  = 8'h0F;
   localparam logic [7:0] ADDR_SLOT_TWO    = 8'h10;
   localparam logic [7:0] ADDR_SLOT_THREE  = 8'h11;
   localparam logic [7:0] ADDR_SLOT_LAST   = 8'h16;

   // slot chain length and field layout
   localparam int SLOT_COUNT  = 8;
   localparam int POS_W       = 3;
   localparam int FLAG_BIT    = 7;
   localparam int VALUE_MSB   = 6;
   localparam int VALUE_W     = 7;
   localparam int TRIG_GO_BIT = 0;

   // reset values
   localparam logic [7:0] SLOT_ONE_RST = 8'h01;
   localparam logic [7:0] SLOT_RST     = 8'h00;

   // idle step timing
   localparam int unsigned CLOCK_HZ    = 25000000;
   localparam int unsigned STEP_MS     = 10;
   localparam int unsigned STEP_CYCLES = (CLOCK_HZ / 1000) * STEP_MS;

   // sequencer states, one-hot
   typedef enum logic [3:0] {
      WSEQ_IDLE  = 4'h1,
      WSEQ_FETCH = 4'h2,
      WSEQ_PLAY  = 4'h4,
      WSEQ_WAIT  = 4'h8
   } wseq_state_t;

endpackage

// ===== wseq_slots.sv
/*
 * Eight-entry waveform sequencer with its slot registers and
 * playback trigger, reached over a plain register port.
 * Assumes the waveform library answers play_start with a one-cycle
 * play_done when a waveform ends, and that the register master
 * never raises read and write strobes together.
 */
//
// Overview of operation
// - slot bit 7 flags delay, bits 6:0 value
// - delay slot idles 10 ms times value
// - plain slot value indexes library waveform
// - trigger bit starts chain at first slot
// - after waveform, next slot plays if non-zero
// - stop at zero entry or eight slots
`timescale 1ns/1ns
module wseq_slots #(
   parameter int unsigned STEP_CYCLES = wseq_pkg::STEP_CYCLES
) (
   // clock and reset
   input  wire logic                        clock,
   input  wire logic                        rst_n,
   // register port
   input  wire logic [wseq_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [wseq_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [wseq_pkg::DATA_W-1:0] reg_rdata,
   // waveform library handshake
   output logic                             play_start,
   output logic      [wseq_pkg::VALUE_W-1:0] play_index,
   input  wire logic                        play_done,
   // status
   output logic                             seq_busy,
   output logic                             seq_delaying
);
   import wseq_pkg::*;

   localparam logic [POS_W-1:0] POS_LAST = POS_W'(SLOT_COUNT - 1);

   typedef struct packed {
      wseq_state_t                state;
      logic [SLOT_COUNT-1:0][7:0] slot;
      logic [POS_W-1:0]           pos;
      logic                       go;
      logic [DATA_W-1:0]          rdata;
      logic                       play_start;
      logic [VALUE_W-1:0]         play_index;
      logic                       dly_start;
      logic [VALUE_W-1:0]         dly_count;
      logic                       dly_abort;
   } wseq_main_t;

   // slot one comes up holding the first library entry
   localparam wseq_main_t ST_RESET = '{
      state:   WSEQ_IDLE,
      slot:    {{(SLOT_COUNT-1){SLOT_RST}}, SLOT_ONE_RST},
      default: '0
   };

   wseq_main_t st_reg;
   wseq_main_t st_next;

   wseq_delay_if dly ();

   // decoded register accesses
   logic               slot_hit;
   logic [POS_W-1:0]   slot_idx;
   logic               trig_hit;
   logic               go_set;
   logic               go_clr;
   logic [7:0]         cur_slot;
   logic               cur_flag;
   logic [VALUE_W-1:0] cur_val;
   logic               step_end;

   assign slot_hit = (reg_addr >= ADDR_SLOT_FIRST) &&
                     (reg_addr <= ADDR_SLOT_LAST);
   assign slot_idx = POS_W'(reg_addr - ADDR_SLOT_FIRST);
   assign trig_hit = (reg_addr == ADDR_TRIG);
   assign go_set   = reg_wr && trig_hit && reg_wdata[TRIG_GO_BIT];
   assign go_clr   = reg_wr && trig_hit && !reg_wdata[TRIG_GO_BIT];

   assign cur_slot = st_reg.slot[st_reg.pos];
   assign cur_flag = cur_slot[FLAG_BIT];
   assign cur_val  = cur_slot[VALUE_MSB:0];

   // a step ends on a library done or an expired idle period
   assign step_end = (st_reg.state == WSEQ_PLAY && play_done) ||
                     (st_reg.state == WSEQ_WAIT && dly.done);

   // next state: registers, read data and sequencer
   always_comb begin
      st_next            = st_reg;
      st_next.play_start = 1'b0;
      st_next.dly_start  = 1'b0;
      st_next.dly_abort  = 1'b0;
      st_next.rdata      = '0;

      // slots stay writable during playback; a new value is
      // seen only when the chain fetches that slot
      if (reg_wr && slot_hit) begin
         st_next.slot[slot_idx] = reg_wdata;
      end

      // read data for the following cycle, unmapped reads zero
      if (reg_rd) begin
         if (slot_hit) begin
            st_next.rdata = st_reg.slot[slot_idx];
         end else if (trig_hit) begin
            st_next.rdata = DATA_W'(st_reg.go);
         end
      end

      unique case (st_reg.state)
         WSEQ_IDLE: begin
            if (go_set) begin
               st_next.state = WSEQ_FETCH;
               st_next.pos   = '0;
               st_next.go    = 1'b1;
            end
         end
         WSEQ_FETCH: begin
            if (cur_val == '0) begin
               st_next.state = WSEQ_IDLE;
               st_next.go    = 1'b0;
            end else if (cur_flag) begin
               st_next.state     = WSEQ_WAIT;
               st_next.dly_start = 1'b1;
               st_next.dly_count = cur_val;
            end else begin
               st_next.state      = WSEQ_PLAY;
               st_next.play_start = 1'b1;
               st_next.play_index = cur_val;
            end
         end
         WSEQ_PLAY, WSEQ_WAIT: begin
            if (step_end) begin
               if (st_reg.pos == POS_LAST) begin
                  st_next.state = WSEQ_IDLE;
                  st_next.go    = 1'b0;
               end else begin
                  st_next.state = WSEQ_FETCH;
                  st_next.pos   = st_reg.pos + POS_W'(1);
               end
            end
         end
      endcase

      // clearing the trigger abandons the chain at once
      if (go_clr) begin
         st_next.state     = WSEQ_IDLE;
         st_next.go        = 1'b0;
         st_next.dly_start = 1'b0;
         st_next.play_start = 1'b0;
         st_next.dly_abort = 1'b1;
      end
   end

   // state register, synchronous reset
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_reg <= ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // timer hookup
   assign dly.start = st_reg.dly_start;
   assign dly.abort = st_reg.dly_abort;
   assign dly.count = st_reg.dly_count;

   wseq_delay #(
      .STEP_CYCLES (STEP_CYCLES)
   ) u_delay (
      .clock (clock),
      .rst_n (rst_n),
      .dly   (dly)
   );

   // outputs, all from flops
   assign reg_rdata    = st_reg.rdata;
   assign play_start   = st_reg.play_start;
   assign play_index   = st_reg.play_index;
   assign seq_busy     = st_reg.go;
   assign seq_delaying = dly.busy;

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   logic fetch_live;
   assign fetch_live = (st_reg.state == WSEQ_FETCH) && !go_clr;

   slot_two_read_a: assert property (
      reg_rd && reg_addr == ADDR_SLOT_TWO && !reg_wr
      |=> reg_rdata == $past(st_reg.slot[1]))
      else $error("slot two read data wrong");

   flag_starts_delay_a: assert property (
      fetch_live && cur_val != '0 && cur_flag
      |=> dly.start && dly.count == $past(cur_val) && !play_start)
      else $error("flagged slot did not start idle period");

   wait_is_silent_a: assert property (
      st_reg.state == WSEQ_WAIT |-> !play_start)
      else $error("waveform issued during idle period");

   delay_runs_a: assert property (
      // a clear in the start cycle cuts the delay short, so skip it
      dly.start && !go_clr |=> seq_delaying [*2])
      else $error("idle timer not running");

   play_index_a: assert property (
      fetch_live && cur_val != '0 && !cur_flag
      |=> play_start && play_index == $past(cur_val))
      else $error("library index not issued");

   trig_first_slot_a: assert property (
      st_reg.state == WSEQ_IDLE && go_set
      |=> st_reg.state == WSEQ_FETCH && st_reg.pos == '0 && seq_busy)
      else $error("trigger did not start at first slot");

   done_advance_a: assert property (
      st_reg.state == WSEQ_PLAY && play_done && !go_clr &&
      st_reg.pos != POS_LAST
      |=> st_reg.state == WSEQ_FETCH &&
          st_reg.pos == $past(st_reg.pos) + POS_W'(1))
      else $error("chain did not advance after waveform");

   zero_stop_a: assert property (
      fetch_live && cur_val == '0
      |=> st_reg.state == WSEQ_IDLE && !seq_busy && !play_start)
      else $error("zero entry did not stop chain");

   eight_stop_a: assert property (
      step_end && st_reg.pos == POS_LAST
      |=> st_reg.state == WSEQ_IDLE && !seq_busy ##1 !play_start)
      else $error("chain ran past eighth slot");

   wait_advance_a: assert property (
      st_reg.state == WSEQ_WAIT && dly.done && !go_clr &&
      st_reg.pos != POS_LAST
      |=> st_reg.state == WSEQ_FETCH &&
          st_reg.pos == $past(st_reg.pos) + POS_W'(1))
      else $error("chain did not advance after idle period");

   // register port and quiet-state checks
   slot_write_a: assert property (
      reg_wr && reg_addr == ADDR_SLOT_THREE
      |=> st_reg.slot[2] == $past(reg_wdata))
      else $error("slot three write lost");

   rdata_idle_a: assert property (
      !reg_rd |=> reg_rdata == '0)
      else $error("read data outside read cycle");

   trig_read_a: assert property (
      reg_rd && trig_hit |=> reg_rdata == DATA_W'($past(seq_busy)))
      else $error("trigger readback wrong");

   // a zero trigger write drops the chain; the timer lets go a
   // cycle later because its abort comes from a flop
   abort_stop_a: assert property (
      go_clr
      |=> st_reg.state == WSEQ_IDLE && !seq_busy && !play_start
      ##1 !seq_delaying && !play_start)
      else $error("trigger clear did not stop chain");

   wait_holds_a: assert property (
      st_reg.state == WSEQ_WAIT && !dly.done && !go_clr
      |=> st_reg.state == WSEQ_WAIT && !play_start)
      else $error("idle period left early");

   play_in_play_a: assert property (
      play_start |-> st_reg.state == WSEQ_PLAY && seq_busy)
      else $error("waveform issued outside playback");

   index_held_a: assert property (
      !play_start |-> $stable(play_index))
      else $error("library index moved without start");

   count_nonzero_a: assert property (
      dly.start |-> dly.count != '0)
      else $error("zero idle period launched");

   idle_quiet_a: assert property (
      st_reg.state == WSEQ_IDLE |-> !seq_busy && !play_start)
      else $error("idle sequencer still active");

   // main scenarios
   delay_slot_c: cover property (
      st_reg.state == WSEQ_WAIT ##1 st_reg.state == WSEQ_FETCH);
   full_chain_c: cover property (
      step_end && st_reg.pos == POS_LAST);
   zero_end_c: cover property (
      fetch_live && cur_val == '0 && st_reg.pos != '0);
   // a trigger clear while an idle slot is timing
   abort_delay_c: cover property (
      go_clr && st_reg.state == WSEQ_WAIT);
   // a waveform follows straight after an idle slot
   play_after_wait_c: cover property (
      st_reg.state == WSEQ_WAIT && dly.done ##2 play_start);

endmodule // wseq_slots

// ===== wseq_testbench.sv
/*
 * Self-checking bench for the waveform sequence slot block: register
 * access, chained playback, idle slots and the eight-slot limit.
 * Assumes the bench plays the waveform library through play_done.
 */
`timescale 1ns/1ns
module testbench;
   import wseq_pkg::*;

   // short idle step keeps delay slots to a few cycles
   localparam int unsigned STEPS = 4;

   logic       clock;
   logic       rst_n;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       play_start;
   logic [6:0] play_index;
   logic       play_done;
   logic       seq_busy;
   logic       seq_delaying;
   int         n_errors;
   int         n_checks;

   wseq_slots #(.STEP_CYCLES(STEPS)) wseq_slots_inst (
      .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .play_start(play_start),
      .play_index(play_index), .play_done(play_done),
      .seq_busy(seq_busy), .seq_delaying(seq_delaying));

   // free-running system clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   task automatic complete_run;
      if (n_errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // byte results
   task automatic chk8(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   // flag results
   task automatic chk1(input string what, input logic exp,
                       input logic got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %b seen %b", what, exp, got);
      end
   endtask

   // one-cycle write strobe, released after the sampling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the read edge
   task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      chk8($sformatf("reg %h", a), exp, reg_rdata);
   endtask

   // counts edges until a waveform start is seen, bounded
   task automatic wait_start(output int n);
      n = 0;
      while (n < 200) begin
         @(posedge clock);
         #1;
         n++;
         if (play_start === 1'b1)
            break;
      end
   endtask

   // library reports end of the current waveform
   task automatic done_pulse;
      @(posedge clock);
      play_done <= 1'b1;
      @(posedge clock);
      play_done <= 1'b0;
   endtask

   task automatic reg_test;
      chk_reg(ADDR_SLOT_FIRST, SLOT_ONE_RST);
      chk_reg(ADDR_SLOT_TWO, SLOT_RST);
      chk_reg(ADDR_SLOT_THREE, SLOT_RST);
      chk_reg(ADDR_TRIG, 8'h00);
      wr(ADDR_SLOT_TWO, 8'h85);
      wr(ADDR_SLOT_THREE, 8'h7F);
      wr(8'h20, 8'hFF);
      chk_reg(ADDR_SLOT_TWO, 8'h85);
      chk_reg(ADDR_SLOT_THREE, 8'h7F);
      chk_reg(8'h20, 8'h00);
      @(posedge clock);
      #1;
      chk8("rdata idle", 8'h00, reg_rdata);
   endtask

   // waveform, flagged idle slot, waveform, then a zero entry
   task automatic chain_test;
      int n;
      int d;
      wr(ADDR_SLOT_FIRST, 8'h05);
      wr(ADDR_SLOT_TWO, 8'h82);
      wr(ADDR_SLOT_THREE, 8'h09);
      wr(ADDR_TRIG, 8'h01);
      wait_start(n);
      chk8("start latency", 8'h01, 8'(n));
      chk8("first index", 8'h05, {1'b0, play_index});
      chk1("busy", 1'b1, seq_busy);
      done_pulse;
      d = 0;
      n = 0;
      while (play_start !== 1'b1 && n < 60) begin
         @(posedge clock);
         #1;
         n++;
         if (seq_delaying === 1'b1)
            d++;
      end
      chk8("idle cycles", 8'(2 * STEPS), 8'(d));
      chk8("after idle", 8'h09, {1'b0, play_index});
      done_pulse;
      repeat (3) @(posedge clock);
      #1;
      chk1("zero stop", 1'b0, seq_busy);
      chk_reg(ADDR_TRIG, 8'h00);
   endtask

   // every slot filled: chain must stop after the last one
   task automatic eight_test;
      int n;
      for (int i = 0; i < SLOT_COUNT; i++)
         wr(ADDR_SLOT_FIRST + 8'(i), 8'(i + 1));
      wr(ADDR_TRIG, 8'h01);
      for (int i = 0; i < SLOT_COUNT; i++) begin
         wait_start(n);
         chk8("next latency", 8'h01, 8'(n));
         chk8("chain index", 8'(i + 1), {1'b0, play_index});
         done_pulse;
      end
      repeat (3) @(posedge clock);
      #1;
      chk1("eight stop", 1'b0, seq_busy);
      chk1("no ninth", 1'b0, play_start);
   endtask

   // a zero written to the trigger drops a running idle slot
   task automatic abort_test;
      int n;
      wr(ADDR_SLOT_FIRST, 8'h85);
      wr(ADDR_SLOT_TWO, 8'h03);
      wr(ADDR_TRIG, 8'h01);
      repeat (6) @(posedge clock);
      #1;
      chk1("delaying", 1'b1, seq_delaying);
      wr(ADDR_TRIG, 8'h00);
      repeat (2) @(posedge clock);
      #1;
      chk1("abort busy", 1'b0, seq_busy);
      chk1("abort idle", 1'b0, seq_delaying);
      wait_start(n);
      chk8("abort no play", 8'hC8, 8'(n));
      chk_reg(ADDR_TRIG, 8'h00);
   endtask

   // main sequence, reset held for sixteen cycles
   initial begin
      n_errors  = 0;
      n_checks  = 0;
      rst_n     = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      play_done = 1'b0;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      reg_test;
      chain_test;
      eight_test;
      abort_test;
      complete_run;
   end

   // watchdog well beyond the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge clock);
      n_errors++;
      complete_run;
   end

endmodule // testbench
